// [design/fir_sequencer.sv]
// Sequencer for an N-tap FIR built from two FIFOs and one MAC
// Notes on behaviour
// - The reread pulse goes low only while read and write strobes are high.
// - In basic mode coefficients are reread every pass and never reloaded.
// - Samples read at taps 1 to N-1 are written back through the mux; tap 0 writes the new sample.
// - The basic filter clock has a 200 ns period with equal halves.
// - The high phase after the last tap drops reread, holds it low 50 ns, then keeps strobes high.
// - The low phase lasts at least 60 ns for FIFO access plus MAC set-up.
// - One filter output is produced per pass of N filter cycles.
// - Fast mode loads coefficients once, then the mux recirculates them.
// - Fast mode uses a 100 ns low and 50 ns high phase with no reread.
// - A four-tap filter takes four cycles and one new sample per output.
`timescale 1ns/1ps
`default_nettype none
module fir_sequencer
    import fir_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Mode control
    input wire logic run,
    input wire logic fast_mode,
    input wire logic coef_loaded,
    input wire logic subtract,
    // New sample stream
    input wire logic sample_valid,
    input wire logic [DATA_W-1:0] sample_in,
    output logic sample_ready,
    // FIFO strobes, active low
    output logic fifo_rd_n,
    output logic fifo_wr_n,
    output logic reread_pulse_n,
    // FIFO read data
    input wire logic [DATA_W-1:0] data_fifo_q,
    input wire logic [DATA_W-1:0] coef_fifo_q,
    // FIFO write data through the muxes
    output logic [DATA_W-1:0] data_fifo_d,
    output logic data_mux_new,
    output logic coef_mux_recirc,
    // Filter result
    output logic [ACC_W-1:0] result,
    output logic result_valid
);
    phase_t ph_r;
    phase_t ph_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [TAP_W-1:0] tap_r;
    logic [DATA_W-1:0] new_r;
    logic end_phase;
    logic load_mac;
    logic step_mac;
    logic first_r;
    logic last_r;
    logic step_r;
    logic done_r;
    logic [ACC_W-1:0] acc;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    // ----------------------------------------
    // Phase timing
    // ----------------------------------------
    always_comb begin
        ph_nxt = ph_r;
        end_phase = 1'b0;
        case (ph_r)
            PH_IDLE: begin
                if (run && sample_valid && (!fast_mode || coef_loaded)) begin
                    ph_nxt = PH_LOW;
                end
            end
            PH_LOW: begin
                end_phase = (cnt_r == cyc(BASIC_LOW_CYC));
                if (end_phase) begin
                    ph_nxt = fast_mode ? PH_HIGH : PH_REREAD;
                end
            end
            PH_HIGH: begin
                end_phase = (cnt_r == cyc(FAST_HIGH_CYC));
                if (end_phase) begin
                    ph_nxt = PH_LOW;
                end
            end
            PH_REREAD: begin
                end_phase = (cnt_r == cyc(REREAD_LOW_CYC));
                if (end_phase) begin
                    ph_nxt = PH_HOLD;
                end
            end
            PH_HOLD: begin
                end_phase = (cnt_r == cyc(STROBE_HOLD_CYC));
                if (end_phase) begin
                    ph_nxt = PH_LOW;
                end
            end
            default: ph_nxt = PH_IDLE;
        endcase
        if (ph_nxt == PH_LOW && ph_r != PH_LOW && ph_r != PH_IDLE
            && tap_r == '0 && !(run && sample_valid)) begin
            ph_nxt = PH_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ph_r <= PH_IDLE;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (end_phase || ph_r == PH_IDLE) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ----------------------------------------
    // Tap counter and pass framing
    // ----------------------------------------
    assign load_mac = (ph_r == PH_LOW) && end_phase;
    assign sample_ready = load_mac && tap_r == '0;
    assign step_mac = load_mac;

    always_ff @(posedge clk) begin
        if (reset) begin
            tap_r <= '0;
        end else if (ph_r == PH_IDLE) begin
            tap_r <= '0;
        end else if (load_mac) begin
            tap_r <= (tap_r == TAP_W'(TAPS - 1)) ? '0 : tap_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            new_r <= '0;
        end else if (sample_ready) begin
            new_r <= sample_in;
        end
    end

    // ----------------------------------------
    // FIFO strobes and muxes
    // ----------------------------------------
    always_comb begin
        fifo_rd_n = !(ph_r == PH_LOW);
        fifo_wr_n = !(ph_r == PH_LOW);
        reread_pulse_n = !(ph_r == PH_REREAD && tap_r == '0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_fifo_d <= '0;
            data_mux_new <= 1'b0;
        end else if (load_mac) begin
            data_mux_new <= (tap_r == '0);
            data_fifo_d <= (tap_r == '0) ? sample_in : data_fifo_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            coef_mux_recirc <= 1'b0;
        end else begin
            coef_mux_recirc <= fast_mode && coef_loaded;
        end
    end

    // ----------------------------------------
    // MAC and result
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            first_r <= 1'b0;
            last_r <= 1'b0;
            step_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            first_r <= load_mac && tap_r == '0;
            last_r <= load_mac && tap_r == TAP_W'(TAPS - 1);
            step_r <= step_mac;
            done_r <= last_r;
        end
    end

    fir_mac u_mac (
        .clk(clk),
        .reset(reset),
        .load(load_mac),
        .sample((tap_r == '0) ? sample_in : data_fifo_q),
        .coef(coef_fifo_q),
        .acc_step(step_r),
        .acc_clear(first_r),
        .subtract(subtract),
        .acc(acc)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= done_r;
            if (done_r) begin
                result <= acc;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_reread_strobes;
        @(posedge clk) disable iff (reset)
        !reread_pulse_n |-> fifo_rd_n && fifo_wr_n;
    endproperty
    a_reread_strobes: assert property (p_reread_strobes)
        else $error("reread while strobes low");

    property p_no_reread_fast;
        @(posedge clk) disable iff (reset)
        fast_mode && $stable(fast_mode) |-> reread_pulse_n;
    endproperty
    a_no_reread_fast: assert property (p_no_reread_fast)
        else $error("reread pulse in fast mode");

    property p_low_len;
        @(posedge clk) disable iff (reset)
        $rose(ph_r == PH_LOW) |-> (ph_r == PH_LOW) [*2];
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("low phase too short");

    property p_reread_len;
        @(posedge clk) disable iff (reset)
        $fell(reread_pulse_n) |-> !reread_pulse_n ##1 reread_pulse_n
            ##0 (fifo_rd_n && fifo_wr_n);
    endproperty
    a_reread_len: assert property (p_reread_len)
        else $error("reread pulse width wrong");

    property p_basic_period;
        @(posedge clk) disable iff (reset)
        !fast_mode && $fell(fifo_rd_n) && $stable(fast_mode)
            |-> ##1 !fifo_rd_n ##1 fifo_rd_n [*2];
    endproperty
    a_basic_period: assert property (p_basic_period)
        else $error("strobe low phase too long");

    property p_ready_tap;
        @(posedge clk) disable iff (reset)
        sample_ready |-> tap_r == '0 && load_mac;
    endproperty
    a_ready_tap: assert property (p_ready_tap)
        else $error("sample taken off pass start");

    property p_result;
        @(posedge clk) disable iff (reset)
        done_r |=> result_valid && result == $past(acc);
    endproperty
    a_result: assert property (p_result)
        else $error("result not presented");

    property p_mux_new;
        @(posedge clk) disable iff (reset)
        sample_ready |=> data_mux_new && data_fifo_d == $past(sample_in);
    endproperty
    a_mux_new: assert property (p_mux_new)
        else $error("new sample not muxed in");
endmodule
`default_nettype wire

// [design/fir_seq_pkg.sv]
// Constants for the FIFO and multiply-accumulate FIR sequencer
package fir_seq_pkg;
    // ----------------------------------------
    // Clock and widths
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TAPS = 4;
    localparam int TAP_W = 2;
    localparam int DATA_W = 16;
    localparam int ACC_W = 40;
    // ----------------------------------------
    // Filter clock timing, basic mode
    // ----------------------------------------
    localparam int BASIC_PERIOD_NS = 120;
    localparam int BASIC_LOW_NS = 60;
    localparam int BASIC_HIGH_NS = 60;
    localparam int REREAD_DELAY_NS = 10;
    localparam int REREAD_LOW_NS = 35;
    localparam int STROBE_HOLD_NS = 10;
    localparam int MIN_HIGH_NS = 55;
    // ----------------------------------------
    // Filter clock timing, fast mode
    // ----------------------------------------
    localparam int FAST_PERIOD_NS = 70;
    localparam int FAST_LOW_NS = 60;
    localparam int FAST_HIGH_NS = 10;
    // ----------------------------------------
    // Cycle counts: least times round up
    // ----------------------------------------
    localparam int BASIC_LOW_CYC =
        (BASIC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_LOW_CYC =
        (FAST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_HIGH_CYC =
        (FAST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REREAD_LOW_CYC =
        (REREAD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HOLD_CYC =
        (STROBE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BASIC_HIGH_CYC = 1 + REREAD_LOW_CYC + STROBE_HOLD_CYC;
    localparam int CNT_W = 3;
    // ----------------------------------------
    // Phase states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_LOW = 3'b001,
        PH_HIGH = 3'b011,
        PH_REREAD = 3'b010,
        PH_HOLD = 3'b110
    } phase_t;
endpackage

// [design/fir_mac.sv]
// Multiply-accumulate unit with registered inputs and result
`timescale 1ns/1ps
`default_nettype none
module fir_mac
    import fir_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Operand capture
    input wire logic load,
    input wire logic [DATA_W-1:0] sample,
    input wire logic [DATA_W-1:0] coef,
    // Accumulate control
    input wire logic acc_step,
    input wire logic acc_clear,
    input wire logic subtract,
    // Result
    output logic [ACC_W-1:0] acc
);
    logic signed [DATA_W-1:0] x_r;
    logic signed [DATA_W-1:0] c_r;
    logic signed [ACC_W-1:0] prod;
    logic signed [ACC_W-1:0] base;

    // ----------------------------------------
    // Input registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            x_r <= '0;
            c_r <= '0;
        end else if (load) begin
            x_r <= sample;
            c_r <= coef;
        end
    end

    assign prod = ACC_W'(x_r) * ACC_W'(c_r);
    assign base = acc_clear ? '0 : $signed(acc);

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            acc <= '0;
        end else if (acc_step) begin
            acc <= subtract ? ACC_W'(base - prod) : ACC_W'(base + prod);
        end
    end
endmodule
`default_nettype wire

// [verification/fir_fifo_model.sv]
// Behavioural data and coefficient FIFOs facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module fir_fifo_model
    import fir_seq_pkg::*;
(
    // Control
    input wire logic reset,
    input wire logic fifo_rd_n,
    input wire logic fifo_wr_n,
    input wire logic reread_pulse_n,
    input wire logic coef_mux_recirc,
    // Data
    input wire logic [DATA_W-1:0] data_fifo_d,
    output logic [DATA_W-1:0] data_fifo_q,
    output logic [DATA_W-1:0] coef_fifo_q
);
    logic [DATA_W-1:0] dmem [0:255];
    int rd_p = 0;
    int wr_p = 0;
    int c_p = 0;
    // Empty reads give a changing pattern
    assign data_fifo_q = (rd_p < wr_p) ? dmem[rd_p] : ~DATA_W'(rd_p);
    assign coef_fifo_q = (c_p < TAPS) ? 16'h0010 + DATA_W'(c_p) : ~DATA_W'(c_p);
    // Preload on reset
    always @(posedge reset) begin
        rd_p = 0;
        wr_p = TAPS;
        c_p = 0;
        for (int i = 0; i < TAPS; i++) begin
            dmem[i] = 16'h0021 + DATA_W'(i);
        end
    end
    // Read position advances on rising read
    always @(posedge fifo_rd_n) begin
        if (!reset) begin
            rd_p = rd_p + 1;
            c_p = coef_mux_recirc ? (c_p + 1) % TAPS : c_p + 1;
        end
    end
    // Rewind coefficients at the end of the pulse
    always @(posedge reread_pulse_n) begin
        c_p = 0;
    end
    // Write completes on rising write
    always @(posedge fifo_wr_n) begin
        if (!reset) begin
            #1;
            dmem[wr_p] = data_fifo_d;
            wr_p = wr_p + 1;
        end
    end
endmodule
`default_nettype wire

// [verification/fir_sequencer_bench.sv]
// Self-checking bench for the FIR sequencer
`timescale 1ns/1ps
`default_nettype none
module fir_sequencer_bench
    import fir_seq_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b0;
    logic run = 1'b0;
    logic fast_mode = 1'b0;
    logic coef_loaded = 1'b0;
    logic subtract = 1'b0;
    logic sample_valid = 1'b0;
    logic [DATA_W-1:0] sample_in = 16'h0005;
    logic sample_ready, fifo_rd_n, fifo_wr_n, reread_pulse_n;
    logic data_mux_new, coef_mux_recirc, result_valid, got_s, prev_rr;
    logic [DATA_W-1:0] data_fifo_q, coef_fifo_q, data_fifo_d;
    logic [DATA_W-1:0] cur_d, cur_c, cur_s, front;
    logic [DATA_W-1:0] exp_q [$];
    logic [ACC_W-1:0] result, sum;
    int fails = 0;
    int n_tests = 0;
    int low_cnt = 0;
    int taps = 0;
    int rr_cnt = 0;
    int n_res = 0;
    int n_low = 0;
    fir_sequencer i_dut (.clk(clk), .reset(reset), .run(run),
        .fast_mode(fast_mode), .coef_loaded(coef_loaded),
        .subtract(subtract), .sample_valid(sample_valid),
        .sample_in(sample_in), .sample_ready(sample_ready),
        .fifo_rd_n(fifo_rd_n), .fifo_wr_n(fifo_wr_n),
        .reread_pulse_n(reread_pulse_n), .data_fifo_q(data_fifo_q),
        .coef_fifo_q(coef_fifo_q), .data_fifo_d(data_fifo_d),
        .data_mux_new(data_mux_new), .coef_mux_recirc(coef_mux_recirc),
        .result(result), .result_valid(result_valid));
    fir_fifo_model i_fifo (.reset(reset), .fifo_rd_n(fifo_rd_n),
        .fifo_wr_n(fifo_wr_n), .reread_pulse_n(reread_pulse_n),
        .coef_mux_recirc(coef_mux_recirc), .data_fifo_d(data_fifo_d),
        .data_fifo_q(data_fifo_q), .coef_fifo_q(coef_fifo_q));
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // ----------------------------------------
    // Compare and verdict
    // ----------------------------------------
    task automatic chk(input logic [ACC_W-1:0] got,
        input logic [ACC_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Port monitor, pre-edge values
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            low_cnt = 0;
            rr_cnt = 0;
            got_s = 1'b0;
            prev_rr = 1'b1;
            exp_q.delete();
            for (int i = 0; i < TAPS; i++) begin
                exp_q.push_back(16'h0021 + DATA_W'(i));
            end
        end else begin
            if (!reread_pulse_n) begin
                rr_cnt++;
                chk(ACC_W'({fifo_rd_n, fifo_wr_n}), ACC_W'(2'b11));
            end
            if (!prev_rr && reread_pulse_n) begin
                chk(ACC_W'(fifo_rd_n), ACC_W'(1'b1));
            end
            prev_rr = reread_pulse_n;
            if (result_valid) begin
                chk(result, subtract ? -sum : sum);
                chk(ACC_W'(taps), ACC_W'(TAPS));
                chk(ACC_W'(rr_cnt), ACC_W'(!fast_mode));
                n_res++;
                rr_cnt = 0;
            end
            if (!fifo_rd_n) begin
                low_cnt++;
                n_low++;
                cur_d = data_fifo_q;
                cur_c = coef_fifo_q;
                if (sample_ready) begin
                    got_s = 1'b1;
                    cur_s = sample_in;
                end
            end else if (low_cnt > 0) begin
                chk(ACC_W'(low_cnt),
                    ACC_W'(fast_mode ? FAST_LOW_CYC : BASIC_LOW_CYC));
                chk(ACC_W'((cur_c - 16'h0010) < DATA_W'(TAPS)), ACC_W'(1'b1));
                front = exp_q.pop_front();
                if (got_s) begin
                    sum = ACC_W'(cur_s) * ACC_W'(cur_c);
                    taps = 1;
                    exp_q.push_back(cur_s);
                end else begin
                    chk(ACC_W'(cur_d), ACC_W'(front));
                    sum = sum + ACC_W'(cur_d) * ACC_W'(cur_c);
                    taps++;
                    exp_q.push_back(cur_d);
                end
                low_cnt = 0;
                got_s = 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic passes(input int n, input logic fast, input logic sub);
        int t0;
        t0 = n_res;
        @(negedge clk);
        fast_mode = fast;
        coef_loaded = fast;
        subtract = sub;
        run = 1'b1;
        sample_valid = 1'b1;
        for (int i = 0; i < 40 * n && n_res < t0 + n; i++) begin
            @(negedge clk);
            if (fifo_rd_n) begin
                sample_in = sample_in + 16'h0003;
            end
        end
        run = 1'b0;
        sample_valid = 1'b0;
        repeat (40) @(negedge clk);
        chk(ACC_W'(n_res >= t0 + n), ACC_W'(1'b1));
    endtask
    task automatic idle_check(input logic fast);
        int n0;
        @(negedge clk);
        fast_mode = fast;
        coef_loaded = 1'b0;
        run = fast;
        sample_valid = 1'b1;
        n0 = n_low;
        repeat (30) @(negedge clk);
        chk(ACC_W'(n_low), ACC_W'(n0));
        run = 1'b0;
        sample_valid = 1'b0;
    endtask
    task automatic do_reset;
        reset = 1'b1;
        repeat (6) @(negedge clk);
        chk(ACC_W'({fifo_rd_n, fifo_wr_n, reread_pulse_n, result_valid}), ACC_W'(4'hE));
        reset = 1'b0;
    endtask
    initial begin
        #1;
        do_reset();
        passes(3, 1'b0, 1'b0);
        passes(1, 1'b0, 1'b1);
        idle_check(1'b0);
        idle_check(1'b1);
        do_reset();
        passes(3, 1'b1, 1'b0);
        passes(1, 1'b1, 1'b1);
        results();
    end
    initial begin
        #(CLK_PERIOD_NS * 5000);
        fails++;
        results();
    end
endmodule
`default_nettype wire
